// file: rtl/sbo_pkg.sv
// package for the standby request and oscillator ready block
// assumes a 32-bit apb slave on pclk and 8-bit registers in the low byte
package sbo_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_STANDBY = 8'h00;
  localparam logic [7:0] OFF_OSC     = 8'h04;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h08;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h0c;
  localparam logic [7:0] OFF_STATE   = 8'h10;

  // ------------------------------------------------------------
  // standby_request_control fields
  // ------------------------------------------------------------
  localparam int HALT_BIT  = 7;
  localparam int DOZE_BIT  = 6;
  localparam int FLOAT_BIT = 5;
  localparam int SOFT_RESET_REQUEST_BIT  = 4;
  localparam int TBW_BIT   = 3;
  localparam logic [7:0] STANDBY_RESET = 8'h00;

  // ------------------------------------------------------------
  // oscillator_ready_and_enable fields: ready in [7:4], enable in [3:0]
  // index 3 low xtal, 2 high xtal, 1 low rc, 0 high rc
  // ------------------------------------------------------------
  localparam int RDY_LSB = 4;
  localparam int EN_LSB  = 0;
  localparam logic [3:0] OSC_EN_RESET = 4'h3;

  // ------------------------------------------------------------
  // interrupt status bits
  // ------------------------------------------------------------
  localparam int EV_ENTER  = 0;
  localparam int EV_WAKE   = 1;
  localparam int EV_IGNORE = 2;
  localparam int EV_SOFT_RESET_REQUEST   = 3;
  localparam int EV_RDY    = 4;

  // ------------------------------------------------------------
  // clock modes seen on the mode monitor
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_LOW_XTAL = 3'h0;
  localparam logic [2:0] MODE_LOW_RC   = 3'h4;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SOFT_RESET_REQUEST_CYCLES = 3; // machine clocks of software reset
  localparam int CNT_W       = 16;

  typedef enum logic [2:0] {
    SBO_RUN      = 3'b000,
    SBO_DOZE     = 3'b001,
    SBO_HALT     = 3'b010,
    SBO_TIMEBASE = 3'b011,
    SBO_WATCH    = 3'b100
  } sbo_state_t;
endpackage

// file: rtl/sbo_standby_osc.sv
// standby request control, software reset and oscillator ready flags
// assumes apb master on pclk; oscillator clocks arrive asynchronously;
// clock mode monitor and interrupt pending come from pclk logic
// soft reset only drives soft_reset_n; this block keeps running through it
//
// Notes on behaviour
// R1: writing halt bit one enters stop mode
// R2: writing doze bit one enters sleep mode
// R3: pending interrupt makes stop sleep watch writes ignored
// R4: float select zero keeps pin levels
// R5: float select one floats pins, pull-ups kept
// R6: soft reset bit gives three-cycle reset pulse
// R7: watch request in main modes enters timebase
// R8: watch request in sub modes enters watch
// R9: request bits read zero, zero writes ignored
// R10: bits two to zero read zero
// R11: priority soft reset, stop, watch, sleep
// R12: software checks mode change done before standby
// R13: release from standby returns to run
// R14: low xtal ready flag read-only after wait
// R15: high xtal ready flag read-only after wait
// R16: low rc ready flag read-only after wait
// R17: high rc ready flag read-only after wait
// R18: wait lasts target, at most one more cycle
// R19: disable clears flag, enable restarts counter
`timescale 1ns/1ps
`default_nettype none
module sbo_standby_osc #(
  parameter int LOW_RC_WAIT  = 64,
  parameter int HIGH_RC_WAIT = 64
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  clock_mode_monitor,
  input  wire logic        intr_pending,
  input  wire logic        wake_event,
  input  wire logic [3:0]  low_wait_sel,
  input  wire logic [3:0]  high_wait_sel,
  input  wire logic [3:0]  osc_clk_in,
  output logic      [2:0]  standby_state,
  output logic             pin_hold,
  output logic             pin_float,
  output logic             soft_reset_n,
  output logic      [3:0]  osc_enable,
  output logic             irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // every flop of the block lives in this one struct
  typedef struct packed {
    sbo_pkg::sbo_state_t                st;
    logic                               flt;
    logic [3:0]                         en;
    logic [1:0]                         soft_reset_request_cnt;
    logic                               soft_reset_request_n;
    logic [3:0]                         s1;
    logic [3:0]                         s2;
    logic [3:0]                         s3;
    logic [3:0]                         acc;
    logic [3:0][sbo_pkg::CNT_W-1:0]     cnt;
    logic [3:0]                         rdy;
    logic [7:0]                         ist;
    logic [7:0]                         msk;
    logic                               irq;
    logic [31:0]                        rdata;
    logic                               rdy_bus;
    logic                               err;
    logic                               hold;
    logic                               hiz;
  } sbo_regs_t;

  sbo_regs_t r;
  sbo_regs_t next_r;

  // ------------------------------------------------------------
  // wait targets in oscillator cycles
  // ------------------------------------------------------------
  // low xtal: 2^(sel)-2 cycles for sel >= 1, sel 0 same as sel 1
  // a target of zero lets the flag rise at the first check
  function automatic logic [sbo_pkg::CNT_W-1:0] low_target(input logic [3:0] sel);
    logic [4:0] e;
    e = (sel == 4'h0) ? 5'h01 : {1'b0, sel};
    low_target = sbo_pkg::CNT_W'((32'h1 << e) - 32'h2);
  endfunction

  // high xtal: one power below the low xtal table, floor of zero
  // selects 0 to 2 all give a zero wait
  function automatic logic [sbo_pkg::CNT_W-1:0] high_target(input logic [3:0] sel);
    logic [4:0] e;
    e = (sel <= 4'h2) ? 5'h01 : (5'(sel) - 5'h01);
    high_target = sbo_pkg::CNT_W'((32'h1 << e) - 32'h2);
  endfunction

  // rc oscillators have a fixed wait set per build
  logic [3:0][sbo_pkg::CNT_W-1:0] target;
  assign target[3] = low_target(low_wait_sel);
  assign target[2] = high_target(high_wait_sel);
  assign target[1] = sbo_pkg::CNT_W'(LOW_RC_WAIT);
  assign target[0] = sbo_pkg::CNT_W'(HIGH_RC_WAIT);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic       acc_wr;
    logic [7:0] wb;
    logic [7:0] ev;
    logic [3:0] tick;
    logic       sub_mode;
    logic       any_req;
    logic       mapped;
    logic [7:0] rd;
    logic       std_wr;
    logic       soft_reset_request_req;
    logic       low_pow;
    // scratch terms start cleared so no latch can form
    acc_wr   = 1'b0;
    wb       = 8'h00;
    ev       = 8'h00;
    tick     = 4'h0;
    sub_mode = 1'b0;
    any_req  = 1'b0;
    mapped   = 1'b0;
    rd       = 8'h00;
    std_wr   = 1'b0;
    soft_reset_request_req = 1'b0;
    low_pow  = 1'b0;
    next_r   = r;

    // ------------------------------------------------------------
    // oscillator ready
    // ------------------------------------------------------------
    // oscillator clock sampling, change taken once stages two and three agree
    // stage one feeds stage two only, never any decision
    next_r.s1 = osc_clk_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < 4; i++)
    begin
      if (r.s2[i] == r.s3[i])
      begin
        next_r.acc[i] = r.s3[i];
        tick[i]       = r.s3[i] & ~r.acc[i];
      end
    end

    // apb write takes effect at the edge where pready is sampled high
    // an unmapped access answers with pslverr and never writes
    acc_wr = psel & penable & r.rdy_bus & pwrite & ~r.err;
    wb     = pwdata[7:0];

    // stabilization counters and ready flags
    // counting stops at the target, so a long wait cannot wrap back
    for (int i = 0; i < 4; i++)
    begin
      if (!r.en[i])
      begin
        next_r.cnt[i] = '0; // R19
        next_r.rdy[i] = 1'b0; // R19
      end
      else if (r.cnt[i] >= target[i])
      begin
        next_r.rdy[i] = 1'b1; // R14 R15 R16 R17 R18
        if (!r.rdy[i])
          ev[sbo_pkg::EV_RDY + i] = 1'b1;
      end
      else if (tick[i])
      begin
        next_r.cnt[i] = r.cnt[i] + 1'b1; // R18
      end
    end

    // ------------------------------------------------------------
    // standby control and software reset
    // ------------------------------------------------------------
    // software reset pulse countdown, low for three cycles then released
    if (r.soft_reset_request_cnt != 2'h0)
    begin
      next_r.soft_reset_request_cnt = r.soft_reset_request_cnt - 2'h1;
      next_r.soft_reset_request_n   = (r.soft_reset_request_cnt == 2'h1);
    end

    // clock mode decides between timebase and watch
    sub_mode = (clock_mode_monitor == sbo_pkg::MODE_LOW_XTAL) ||
               (clock_mode_monitor == sbo_pkg::MODE_LOW_RC);

    // control write: float select always lands, requests are decoded
    std_wr   = acc_wr && (paddr == sbo_pkg::OFF_STANDBY);
    soft_reset_request_req = std_wr && wb[sbo_pkg::SOFT_RESET_REQUEST_BIT];
    any_req  = std_wr && !soft_reset_request_req &&
               (wb[sbo_pkg::HALT_BIT] || wb[sbo_pkg::DOZE_BIT] || wb[sbo_pkg::TBW_BIT]);
    if (std_wr)
      next_r.flt = wb[sbo_pkg::FLOAT_BIT]; // R4 R5

    // software reset outranks every request and ignores pending interrupts
    if (soft_reset_request_req)
    begin
      next_r.soft_reset_request_cnt      = 2'(sbo_pkg::SOFT_RESET_REQUEST_CYCLES); // R6 R11
      next_r.soft_reset_request_n        = 1'b0; // R6
      ev[sbo_pkg::EV_SOFT_RESET_REQUEST] = 1'b1;
    end

    // standby state machine: requests act only from run
    case (r.st)
      sbo_pkg::SBO_RUN:
      begin
        if (any_req && intr_pending)
        begin
          ev[sbo_pkg::EV_IGNORE] = 1'b1; // R3
        end
        else if (any_req && wb[sbo_pkg::HALT_BIT])
        begin
          next_r.st             = sbo_pkg::SBO_HALT; // R1 R11
          ev[sbo_pkg::EV_ENTER] = 1'b1;
        end
        else if (any_req && wb[sbo_pkg::TBW_BIT])
        begin
          next_r.st             = sub_mode ? sbo_pkg::SBO_WATCH // R8
                                           : sbo_pkg::SBO_TIMEBASE; // R7 R11
          ev[sbo_pkg::EV_ENTER] = 1'b1;
        end
        else if (any_req && wb[sbo_pkg::DOZE_BIT])
        begin
          next_r.st             = sbo_pkg::SBO_DOZE; // R2 R11
          ev[sbo_pkg::EV_ENTER] = 1'b1;
        end
      end
      sbo_pkg::SBO_DOZE,
      sbo_pkg::SBO_HALT,
      sbo_pkg::SBO_TIMEBASE,
      sbo_pkg::SBO_WATCH:
      begin
        // a request while already in standby is refused, not queued
        if (any_req)
        begin
          ev[sbo_pkg::EV_IGNORE] = 1'b1;
        end
        if (wake_event)
        begin
          next_r.st            = sbo_pkg::SBO_RUN; // R13
          ev[sbo_pkg::EV_WAKE] = 1'b1;
        end
      end
      default:
      begin
        // unused codes fall back to run so the machine cannot lock up
        next_r.st = sbo_pkg::SBO_RUN;
      end
    endcase

    // ------------------------------------------------------------
    // registers and bus
    // ------------------------------------------------------------
    // enable and mask writes; ready bits are not writable
    if (acc_wr && paddr == sbo_pkg::OFF_OSC)
    begin
      next_r.en = wb[3:0]; // R14 R15 R16 R17
    end
    if (acc_wr && paddr == sbo_pkg::OFF_IRQ_MSK)
    begin
      next_r.msk = wb;
    end

    // sticky status: set wins over write-one-clear
    if (acc_wr && paddr == sbo_pkg::OFF_IRQ_ST)
    begin
      next_r.ist = (r.ist & ~wb) | ev;
    end
    else
    begin
      next_r.ist = r.ist | ev;
    end
    // irq level follows the new status and mask at the same edge
    next_r.irq = |(next_r.ist & next_r.msk);

    // pin behaviour in stop, timebase and watch; sleep leaves pins running
    low_pow     = (next_r.st == sbo_pkg::SBO_HALT) ||
                  (next_r.st == sbo_pkg::SBO_TIMEBASE) ||
                  (next_r.st == sbo_pkg::SBO_WATCH);
    next_r.hold = low_pow && !next_r.flt; // R4
    next_r.hiz  = low_pow && next_r.flt; // R5

    // apb read mux and one wait state
    // read data is taken one cycle ahead and stands with pready
    case (paddr)
      sbo_pkg::OFF_STANDBY:
      begin
        mapped = 1'b1;
        rd     = 8'h00;
        rd[sbo_pkg::FLOAT_BIT] = r.flt; // R9 R10
      end
      sbo_pkg::OFF_OSC:
      begin
        mapped = 1'b1;
        rd     = {r.rdy, r.en};
      end
      sbo_pkg::OFF_IRQ_ST:
      begin
        mapped = 1'b1;
        rd     = r.ist;
      end
      sbo_pkg::OFF_IRQ_MSK:
      begin
        mapped = 1'b1;
        rd     = r.msk;
      end
      sbo_pkg::OFF_STATE:
      begin
        mapped = 1'b1;
        rd     = {5'h00, r.st};
      end
      default:
      begin
        mapped = 1'b0;
        rd     = 8'h00;
      end
    endcase
    // pready for one cycle only, then low for the next setup
    if (psel && penable && !r.rdy_bus)
    begin
      next_r.rdy_bus = 1'b1;
      next_r.err     = ~mapped;
      next_r.rdata   = (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, rd};
    end
    else
    begin
      next_r.rdy_bus = 1'b0;
      next_r.err     = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    // reset loads constants only
    if (!presetn)
    begin
      r          <= '0;
      r.st       <= sbo_pkg::SBO_RUN;
      r.flt      <= sbo_pkg::STANDBY_RESET[sbo_pkg::FLOAT_BIT];
      r.en       <= sbo_pkg::OSC_EN_RESET;
      r.soft_reset_request_n   <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flops
  // ------------------------------------------------------------
  assign prdata        = r.rdata;
  assign pready        = r.rdy_bus;
  assign pslverr       = r.err;
  assign standby_state = r.st;
  assign pin_hold      = r.hold;
  assign pin_float     = r.hiz;
  assign soft_reset_n  = r.soft_reset_request_n;
  assign osc_enable    = r.en;
  assign irq           = r.irq;

endmodule
`default_nettype wire

// file: test/sbo_standby_osc_asserts.sv
// checker for the standby request and oscillator ready block
// assumes it is bound onto sbo_standby_osc and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module sbo_standby_osc_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [2:0]  clock_mode_monitor,
  input wire logic        intr_pending,
  input wire logic        wake_event,
  input wire logic [2:0]  standby_state,
  input wire logic        pin_hold,
  input wire logic        pin_float,
  input wire logic        soft_reset_n
);
  // ----------------------------------------------------------
  // helper terms
  // ----------------------------------------------------------
  logic acc;
  logic wr0;
  logic ok;
  logic sub;
  // completed access, control write, request allowed, sub mode
  assign acc = psel & penable & pready & (paddr == sbo_pkg::OFF_STANDBY);
  assign wr0 = acc & pwrite;
  assign ok  = !intr_pending && standby_state == 3'h0;
  assign sub = clock_mode_monitor == 3'h0 || clock_mode_monitor == 3'h4;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // reset pulse: three low cycles then high again
  sequence s_rst3;
    !soft_reset_n [*3] ##1 soft_reset_n;
  endsequence

  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  a_soft_reset_request_pulse: assert property (wr0 && pwdata[4] |=> s_rst3)
    else $error("soft reset pulse wrong");
  a_halt_enter: assert property (wr0 && pwdata[7] && !pwdata[4] && ok
    |=> standby_state == 3'h2) else $error("stop not entered");
  a_doze_enter: assert property (wr0 && pwdata[7:6] == 2'b01
    && pwdata[4:3] == 2'b00 && ok |=> standby_state == 3'h1)
    else $error("sleep not entered");
  a_watch_enter: assert property (wr0 && !pwdata[7] && pwdata[4:3] == 2'b01
    && ok |=> standby_state == (sub ? 3'h4 : 3'h3)) else $error("watch wrong");
  a_req_ignore: assert property (wr0 && !pwdata[4] && intr_pending
    && standby_state == 3'h0 |=> $stable(standby_state))
    else $error("request not ignored");
  a_pin_lowpow: assert property (standby_state inside {3'h2, 3'h3, 3'h4}
    |-> pin_hold != pin_float) else $error("pin state wrong");
  a_pin_run: assert property (standby_state inside {3'h0, 3'h1}
    |-> !pin_hold && !pin_float) else $error("pins active in run");
  a_wake_run: assert property (standby_state != 3'h0 && wake_event
    |=> standby_state == 3'h0) else $error("no return to run");
  a_read_zero: assert property (acc && !pwrite
    |-> (prdata & ~32'h20) == 32'h0) else $error("control read not zero");
endmodule
bind sbo_standby_osc sbo_standby_osc_asserts u_sbo_standby_osc_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .clock_mode_monitor(clock_mode_monitor),
  .intr_pending(intr_pending), .wake_event(wake_event),
  .standby_state(standby_state), .pin_hold(pin_hold),
  .pin_float(pin_float), .soft_reset_n(soft_reset_n));
`default_nettype wire

// file: test/sbo_standby_osc_tb.sv
// self-checking bench for the standby request and oscillator ready block
// assumes the checker file is compiled alongside with its bind
`timescale 1ns/1ps
`default_nettype none
module sbo_standby_osc_tb;
  localparam logic [7:0] A_SB = sbo_pkg::OFF_STANDBY;
  localparam logic [7:0] A_OS = sbo_pkg::OFF_OSC;
  localparam logic [7:0] A_ST = sbo_pkg::OFF_IRQ_ST;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic        intr_pending, wake_event, pin_hold, pin_float, soft_reset_n;
  logic        irq, osc_run;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  clock_mode_monitor, standby_state;
  logic [3:0]  low_wait_sel, high_wait_sel, osc_clk_in, osc_enable;
  int          error_cnt, samples_checked, tick;
  // request table: data, clock mode, expected state
  logic [7:0]  req_d [7] = '{8'h80, 8'h40, 8'h28, 8'h08, 8'h08, 8'he8, 8'h48};
  logic [2:0]  req_m [7] = '{3'h2, 3'h0, 3'h0, 3'h4, 3'h2, 3'h2, 3'h6};
  logic [2:0]  req_s [7] = '{3'h2, 3'h1, 3'h4, 3'h4, 3'h3, 3'h2, 3'h3};

  sbo_standby_osc #(.LOW_RC_WAIT(4), .HIGH_RC_WAIT(4)) u_sbo_standby_osc (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clock_mode_monitor(clock_mode_monitor),
    .intr_pending(intr_pending), .wake_event(wake_event),
    .low_wait_sel(low_wait_sel), .high_wait_sel(high_wait_sel),
    .osc_clk_in(osc_clk_in), .standby_state(standby_state), .pin_hold(pin_hold),
    .pin_float(pin_float), .soft_reset_n(soft_reset_n),
    .osc_enable(osc_enable), .irq(irq));

  // ----------------------------------------------------------
  // clock, slow oscillator clocks, watchdog
  // ----------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // oscillators toggle every six pclk cycles while running
  always @(posedge pclk)
  begin
    tick <= (tick == 5) ? 0 : tick + 1;
    if (osc_run && tick == 0)
      osc_clk_in <= ~osc_clk_in;
  end
  initial
  begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // each rising edge sees the values that stood just before it
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
      chk("apb ready", {31'h0, pready}, 32'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, intr_pending, wake_event, osc_run} = '0;
    {paddr, pwdata, clock_mode_monitor, osc_clk_in, tick} = '0;
    low_wait_sel = 4'h4;
    high_wait_sel = 4'h4;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_SB, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b0, A_OS, 32'h0);
    chk("osc reset", rd, 32'h3);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {rd[31:1], se}, 32'h1);
    // all request bits at once: soft reset wins
    apb(1'b1, A_SB, 32'hff);
    @(negedge pclk);
    chk("soft_reset_request low", 32'(soft_reset_n), 32'h0);
    chk("soft_reset_request state", 32'(standby_state), 32'h0);
    repeat (3) @(negedge pclk);
    chk("soft_reset_request high", 32'(soft_reset_n), 32'h1);
    for (int i = 0; i < 7; i++)
    begin
      clock_mode_monitor <= req_m[i];
      apb(1'b1, A_SB, {24'h0, req_d[i]});
      @(negedge pclk);
      chk("state", 32'(standby_state), 32'(req_s[i]));
      chk("pins", {pin_hold, pin_float},
          (req_s[i] == 3'h1) ? 32'h0 : (req_d[i][5] ? 32'h1 : 32'h2));
      apb(1'b0, A_SB, 32'h0);
      chk("ctrl read", rd, {26'h0, req_d[i][5], 5'h0});
      @(posedge pclk);
      wake_event <= 1'b1;
      @(posedge pclk);
      wake_event <= 1'b0;
      @(negedge pclk);
      chk("woken", 32'(standby_state), 32'h0);
    end
    // pending interrupt blocks a request; event shows on irq
    apb(1'b1, A_ST, 32'hff);
    intr_pending <= 1'b1;
    apb(1'b1, A_SB, 32'h40);
    @(negedge pclk);
    chk("ignored", 32'(standby_state), 32'h0);
    apb(1'b0, A_ST, 32'h0);
    chk("status", rd, 32'h4);
    apb(1'b1, sbo_pkg::OFF_IRQ_MSK, 32'h4);
    repeat (2) @(negedge pclk);
    chk("irq set", 32'(irq), 32'h1);
    apb(1'b1, A_ST, 32'h4);
    repeat (2) @(negedge pclk);
    chk("irq clear", 32'(irq), 32'h0);
    intr_pending <= 1'b0;
    // oscillator ready flags: wait, rise, clear on disable
    apb(1'b1, A_OS, 32'hff);
    osc_run <= 1'b1;
    apb(1'b0, A_OS, 32'h0);
    chk("rdy early", rd, 32'h0f);
    repeat (400) @(posedge pclk);
    apb(1'b0, A_OS, 32'h0);
    chk("rdy all", rd, 32'hff);
    apb(1'b1, A_OS, 32'hf3);
    @(negedge pclk);
    chk("osc enable", 32'(osc_enable), 32'h3);
    apb(1'b0, A_OS, 32'h0);
    chk("rdy off", rd, 32'h33);
    // re-enabled crystals must wait again from zero
    apb(1'b1, A_OS, 32'h0f);
    apb(1'b0, A_OS, 32'h0);
    chk("rdy restart", rd, 32'h3f);
    end_of_test();
  end
endmodule
`default_nettype wire
